//--- logic/rpo_pkg.sv
// Purpose: Shared constants and types for the pulse retransmit output block
// Assumes: 200 MHz reference clock, APB register access with 32-bit data
// Notes:   Register offsets are byte addresses of aligned words
`default_nettype none
package rpo_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_DIV    = 12'h004;
  localparam logic [11:0] OFS_WIDTH  = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_EVENT  = 12'h010;

  // Control register field positions
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_SRC_LSB     = 1;
  localparam int CTRL_SUB_BIT     = 3;

  // Event register field positions (write one to act)
  localparam int EVT_CLR_A_BIT = 0;
  localparam int EVT_CLR_B_BIT = 1;

  // Status register field positions
  localparam int STAT_QUEUE_LSB = 0;
  localparam int STAT_OUT_BIT   = 16;
  localparam int STAT_BUSY_BIT  = 17;
  localparam int STAT_AVAIL_BIT = 18;

  // Field widths
  localparam int DIV_W   = 16;
  localparam int QUEUE_W = 16;
  localparam int WSEL_W  = 4;
  localparam int MS_W    = 10;

  // Reset values
  localparam logic              RST_ENABLE = 1'b0;
  localparam logic [DIV_W-1:0]  RST_DIV    = 16'h0001;
  localparam logic [WSEL_W-1:0] RST_WSEL   = 4'h0;

  // Timing: one millisecond in nanoseconds and the clock period
  localparam int MS_TIME_NS    = 1000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYC_PER_MS    = MS_TIME_NS / CLK_PERIOD_NS;

  // Number of selectable pulse widths
  localparam int WIDTH_COUNT = 11;
  localparam logic [WSEL_W-1:0] WSEL_MAX = 4'ha;

  // Output source selection codes
  typedef enum logic [1:0]
  {
    SRC_COPY_A = 2'b00,
    SRC_COPY_B = 2'b01,
    SRC_SCALED = 2'b10,
    SRC_NONE   = 2'b11
  } rpo_src_t;

  // Configuration carried from the register file into the generator
  typedef struct packed
  {
    logic              enable;
    rpo_src_t          source;
    logic              composite_sub;
    logic [DIV_W-1:0]  divisor;
    logic [WSEL_W-1:0] width_sel;
  } rpo_cfg_t;

  // Pulse width in milliseconds for a selector value
  function automatic logic [MS_W-1:0] width_ms(input logic [WSEL_W-1:0] sel);
    logic [MS_W-1:0] ms;
    ms = 10'h00a;
    case (sel)
      4'h0:    ms = 10'h00a;
      4'h1:    ms = 10'h014;
      4'h2:    ms = 10'h032;
      4'h3:    ms = 10'h064;
      4'h4:    ms = 10'h0c8;
      4'h5:    ms = 10'h12c;
      4'h6:    ms = 10'h190;
      4'h7:    ms = 10'h1f4;
      4'h8:    ms = 10'h258;
      4'h9:    ms = 10'h320;
      default: ms = 10'h3e8;
    endcase
    return ms;
  endfunction

endpackage
`default_nettype wire

//--- logic/rpo_ms_tick.sv
// Purpose: Millisecond tick divider with synchronous restart
// Assumes: Single reference clock, restart comes from the same clock domain
// Notes:   Tick is a one-cycle enable, first tick one full period after restart
`default_nettype none
module rpo_ms_tick #(
  parameter int CYC_PER_MS = rpo_pkg::CYC_PER_MS
)(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic restart_i,
  output var  logic tick_o
);

  localparam logic [17:0] LAST = 18'(CYC_PER_MS - 1);

  logic [17:0] count;

  // Free counter, restarted at each pulse start and at each pulse end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count  <= 18'h00000;
      tick_o <= 1'b0;
    end
    else if (restart_i)
    begin
      count  <= 18'h00000;
      tick_o <= 1'b0;
    end
    else if (count == LAST)
    begin
      count  <= 18'h00000;
      tick_o <= 1'b1;
    end
    else
    begin
      count  <= count + 18'h00001;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- logic/rpo_pulse_out.sv
// Purpose: Retransmitted pulse output generator with APB configuration
// Assumes: Input pins A and b are asynchronous; total increment and total
//          clears come from logic on the same clock as one-cycle pulses
// Notes:   Output high means the open-collector transistor is on
//
// Behaviour
// - Output follows copy of input A, copy of input b, or scaled total.
// - Scaled mode counts one pulse per composite total digit increment.
// - Scaled source unavailable when composite total is A minus b.
// - Annunciator follows transistor when scaled, lit steadily when copying.
// - Divisor and width act only while scaled source is selected.
// - Scaled pulses are divided, one output per divisor increments.
// - Each scaled pulse lasts one of eleven millisecond widths.
// - Surplus divided pulses queue and go out in turn, each followed by an off gap as long as the width.
// - Clearing total A or total b discards queued pulses.
// - Queued count starts at zero after reset.
`default_nettype none
module rpo_pulse_out #(
  parameter int CYC_PER_MS = rpo_pkg::CYC_PER_MS
)(
  input  wire logic        REF_CLK_I,
  input  wire logic        ARST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output var  logic [31:0] PRDATA_O,
  output var  logic        PREADY_O,
  output var  logic        PSLVERR_O,
  // Pulse inputs from pins
  input  wire logic        PULSE_A_I,
  input  wire logic        PULSE_B_I,
  // Composite total events from the totaliser core
  input  wire logic        TOTAL_LSD_INC_I,
  input  wire logic        TOTAL_A_CLR_I,
  input  wire logic        TOTAL_B_CLR_I,
  // Outputs
  output var  logic        PULSE_OUT_O,
  output var  logic        RETRANSMIT_ANNUNCIATOR_O
);

  rpo_pkg::rpo_cfg_t cfg;

  logic [1:0]                    sync_a;
  logic [1:0]                    sync_b;
  logic                          apb_access;
  logic                          apb_commit;
  logic                          wr_ctrl;
  logic                          wr_div;
  logic                          wr_width;
  logic                          wr_event;
  logic                          sw_clr;
  logic                          queue_clear;
  logic                          scaled_active;
  logic                          divided_pulse;
  logic [rpo_pkg::DIV_W-1:0]     div_count;
  logic [rpo_pkg::QUEUE_W-1:0]   queue;
  logic                          busy;
  logic                          in_gap;
  logic                          pulse_on;
  logic [rpo_pkg::MS_W-1:0]      ms_count;
  logic [rpo_pkg::MS_W-1:0]      width_now;
  logic                          start_pulse;
  logic                          ms_tick;
  logic                          next_out;
  logic [31:0]                   next_rdata;
  logic                          next_err;

  // Address match for one register, used by every decode
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  // Two-stage synchronisers for the asynchronous pulse pins
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      sync_a <= 2'b00;
      sync_b <= 2'b00;
    end
    else
    begin
      sync_a <= {sync_a[0], PULSE_A_I};
      sync_b <= {sync_b[0], PULSE_B_I};
    end
  end

  // APB phases: answer prepared, then committed when pready is seen
  assign apb_access = PSEL_I && PENABLE_I && !PREADY_O;
  assign apb_commit = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_ctrl    = apb_commit && PWRITE_I && hit(PADDR_I, rpo_pkg::OFS_CTRL);
  assign wr_div     = apb_commit && PWRITE_I && hit(PADDR_I, rpo_pkg::OFS_DIV);
  assign wr_width   = apb_commit && PWRITE_I && hit(PADDR_I, rpo_pkg::OFS_WIDTH);
  assign wr_event   = apb_commit && PWRITE_I && hit(PADDR_I, rpo_pkg::OFS_EVENT);

  // Software total clears count as total resets too
  assign sw_clr = wr_event && (PWDATA_I[rpo_pkg::EVT_CLR_A_BIT]
                               || PWDATA_I[rpo_pkg::EVT_CLR_B_BIT]);

  // Control register
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cfg.enable        <= rpo_pkg::RST_ENABLE;
      cfg.source        <= rpo_pkg::SRC_COPY_A;
      cfg.composite_sub <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      cfg.enable        <= PWDATA_I[rpo_pkg::CTRL_ENABLE_BIT];
      cfg.source        <= rpo_pkg::rpo_src_t'(PWDATA_I[rpo_pkg::CTRL_SRC_LSB +: 2]);
      cfg.composite_sub <= PWDATA_I[rpo_pkg::CTRL_SUB_BIT];
    end
  end

  // Divisor register, zero is held as one
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cfg.divisor <= rpo_pkg::RST_DIV;
    end
    else if (wr_div)
    begin
      if (PWDATA_I[rpo_pkg::DIV_W-1:0] == '0)
      begin
        cfg.divisor <= rpo_pkg::RST_DIV;
      end
      else
      begin
        cfg.divisor <= PWDATA_I[rpo_pkg::DIV_W-1:0];
      end
    end
  end

  // Width selector register, values past the last entry clamp to it
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cfg.width_sel <= rpo_pkg::RST_WSEL;
    end
    else if (wr_width)
    begin
      if (PWDATA_I[rpo_pkg::WSEL_W-1:0] > rpo_pkg::WSEL_MAX)
      begin
        cfg.width_sel <= rpo_pkg::WSEL_MAX;
      end
      else
      begin
        cfg.width_sel <= PWDATA_I[rpo_pkg::WSEL_W-1:0];
      end
    end
  end

  // Read mux and error for unmapped addresses
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (hit(PADDR_I, rpo_pkg::OFS_CTRL))
    begin
      next_rdata[rpo_pkg::CTRL_ENABLE_BIT]       = cfg.enable;
      next_rdata[rpo_pkg::CTRL_SRC_LSB +: 2]     = cfg.source;
      next_rdata[rpo_pkg::CTRL_SUB_BIT]          = cfg.composite_sub;
    end
    else if (hit(PADDR_I, rpo_pkg::OFS_DIV))
    begin
      next_rdata[rpo_pkg::DIV_W-1:0] = cfg.divisor;
    end
    else if (hit(PADDR_I, rpo_pkg::OFS_WIDTH))
    begin
      next_rdata[rpo_pkg::WSEL_W-1:0] = cfg.width_sel;
    end
    else if (hit(PADDR_I, rpo_pkg::OFS_STATUS))
    begin
      next_rdata[rpo_pkg::STAT_QUEUE_LSB +: rpo_pkg::QUEUE_W] = queue;
      next_rdata[rpo_pkg::STAT_OUT_BIT]   = PULSE_OUT_O;
      next_rdata[rpo_pkg::STAT_BUSY_BIT]  = busy;
      next_rdata[rpo_pkg::STAT_AVAIL_BIT] = !cfg.composite_sub;
    end
    else if (hit(PADDR_I, rpo_pkg::OFS_EVENT))
    begin
      next_rdata = 32'h00000000;
    end
    else
    begin
      next_err = 1'b1;
    end
  end

  // APB answer: one wait state, ready for a single cycle
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end
    else if (apb_access)
    begin
      PREADY_O  <= 1'b1;
      PRDATA_O  <= PWRITE_I ? 32'h00000000 : next_rdata;
      PSLVERR_O <= next_err;
    end
    else
    begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end
  end

  // Scaled path runs only when enabled, selected and the total is a sum
  assign scaled_active = cfg.enable && (cfg.source == rpo_pkg::SRC_SCALED)
                         && !cfg.composite_sub;
  assign queue_clear = !scaled_active || TOTAL_A_CLR_I || TOTAL_B_CLR_I || sw_clr;
  assign divided_pulse = scaled_active && TOTAL_LSD_INC_I
                         && (div_count == cfg.divisor - 16'h0001);
  // A clear in the same cycle must not launch a pulse it just discarded
  assign start_pulse = !queue_clear && !busy && !in_gap && (queue != '0);
  assign width_now   = rpo_pkg::width_ms(cfg.width_sel);

  // Divider of total digit increments
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      div_count <= '0;
    end
    else if (queue_clear)
    begin
      div_count <= '0;
    end
    else if (TOTAL_LSD_INC_I)
    begin
      if (divided_pulse)
      begin
        div_count <= '0;
      end
      else
      begin
        div_count <= div_count + 16'h0001;
      end
    end
  end

  // Queue of divided pulses awaiting transmission, saturating
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      queue <= '0;
    end
    else if (queue_clear)
    begin
      queue <= '0;
    end
    else if (divided_pulse && !start_pulse && (queue != '1))
    begin
      queue <= queue + 16'h0001;
    end
    else if (start_pulse && !divided_pulse)
    begin
      queue <= queue - 16'h0001;
    end
  end

  // Millisecond tick, restarted at each pulse edge for exact widths
  rpo_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ms_tick (
    .clk_i     (REF_CLK_I),
    .arst_n_i  (ARST_N_I),
    .restart_i (start_pulse || (busy && !in_gap && ms_tick && ms_count == width_now)),
    .tick_o    (ms_tick)
  );

  // Pulse timer: on for the width, then off for the width before the next
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      busy     <= 1'b0;
      in_gap   <= 1'b0;
      pulse_on <= 1'b0;
      ms_count <= '0;
    end
    else if (!scaled_active)
    begin
      busy     <= 1'b0;
      in_gap   <= 1'b0;
      pulse_on <= 1'b0;
      ms_count <= '0;
    end
    else if (start_pulse)
    begin
      busy     <= 1'b1;
      pulse_on <= 1'b1;
      ms_count <= 10'h001;
    end
    else if (busy && ms_tick)
    begin
      if (ms_count == width_now)
      begin
        busy     <= 1'b0;
        in_gap   <= 1'b1;
        pulse_on <= 1'b0;
        ms_count <= 10'h001;
      end
      else
      begin
        ms_count <= ms_count + 10'h001;
      end
    end
    else if (in_gap && ms_tick)
    begin
      if (ms_count == width_now)
      begin
        in_gap   <= 1'b0;
        ms_count <= '0;
      end
      else
      begin
        ms_count <= ms_count + 10'h001;
      end
    end
  end

  // Output source selection
  always_comb
  begin
    next_out = 1'b0;
    if (cfg.enable)
    begin
      case (cfg.source)
        rpo_pkg::SRC_COPY_A: next_out = sync_a[1];
        rpo_pkg::SRC_COPY_B: next_out = sync_b[1];
        rpo_pkg::SRC_SCALED: next_out = pulse_on && scaled_active;
        default:             next_out = 1'b0;
      endcase
    end
  end

  // Registered transistor drive and annunciator
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PULSE_OUT_O              <= 1'b0;
      RETRANSMIT_ANNUNCIATOR_O <= 1'b0;
    end
    else
    begin
      PULSE_OUT_O <= next_out;
      if (cfg.enable && (cfg.source == rpo_pkg::SRC_COPY_A
                         || cfg.source == rpo_pkg::SRC_COPY_B))
      begin
        RETRANSMIT_ANNUNCIATOR_O <= 1'b1;
      end
      else
      begin
        RETRANSMIT_ANNUNCIATOR_O <= next_out;
      end
    end
  end

endmodule
`default_nettype wire

//--- verification/rpo_pulse_rx.sv
// Purpose: Remote counter fed by the retransmitted pulse output
// Assumes: Output high means transistor on, line sampled on the clock
// Notes:   Reports pulse count and width of the last pulse in cycles
`default_nettype none
module rpo_pulse_rx (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        line_i,
  output var  logic [15:0] count_o,
  output var  logic [15:0] width_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        prev;
  logic [15:0] run;

  // Count rising edges and time each high phase
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev    <= 1'b0;
      run     <= 16'h0000;
      count_o <= 16'h0000;
      width_o <= 16'h0000;
    end
    else
    begin
      prev <= line_i;
      run  <= line_i ? run + 16'h0001 : 16'h0000;
      if (line_i && !prev)
        count_o <= count_o + 16'h0001;
      if (!line_i && prev)
        width_o <= run;
    end
  end
endmodule
`default_nettype wire

//--- verification/rpo_pulse_out_sva.sv
// Purpose: Concurrent checks on the pulse retransmit output ports
// Assumes: Control word tracked from completed register writes
// Notes:   Scaled pulse width and gap checked for a minimum only
`default_nettype none
module rpo_pulse_out_sva (
  input wire logic        REF_CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        PULSE_A_I,
  input wire logic        PULSE_OUT_O,
  input wire logic        RETRANSMIT_ANNUNCIATOR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctrl;
  logic       copy_a;
  logic       copy;
  logic       scaled;
  logic       quiet;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Shadow of the control word
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ctrl <= 4'h0;
    else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
             && PADDR_I == rpo_pkg::OFS_CTRL)
      ctrl <= PWDATA_I[3:0];
  end

  // Mode decode
  assign copy_a = ctrl[0] && ctrl[2:1] == 2'b00;
  assign copy   = ctrl[0] && !ctrl[2];
  assign scaled = ctrl[0] && ctrl[2:1] == 2'b10 && !ctrl[3];
  assign quiet  = !ctrl[0] || ctrl[2:1] == 2'b11 || (ctrl[2:1] == 2'b10 && ctrl[3]);

  chk_ready_once: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held");
  chk_ready_answer: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("no ready");
  chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_annun_out: assert property (PULSE_OUT_O |-> RETRANSMIT_ANNUNCIATOR_O)
    else $error("annunciator dark while on");
  chk_annun_follow: assert property (!copy && !$past(copy)
    |-> RETRANSMIT_ANNUNCIATOR_O == PULSE_OUT_O)
    else $error("annunciator differs from output");
  chk_copy_lit: assert property (copy && $past(copy, 3) |-> RETRANSMIT_ANNUNCIATOR_O)
    else $error("annunciator dark in copy");
  chk_copy_a: assert property (copy_a && $past(copy_a, 5) |-> PULSE_OUT_O == $past(PULSE_A_I, 3))
    else $error("copy of pin a wrong");
  chk_quiet_off: assert property (quiet && $past(quiet, 4) |-> !PULSE_OUT_O)
    else $error("output on while quiet");
  chk_scaled_min: assert property (scaled && $rose(PULSE_OUT_O) |=> PULSE_OUT_O[*8])
    else $error("scaled pulse too short");
  chk_scaled_gap: assert property (scaled && $fell(PULSE_OUT_O) |=> !PULSE_OUT_O[*8])
    else $error("scaled gap too short");
endmodule
`default_nettype wire

//--- verification/rpo_pulse_out_tb_top.sv
// Purpose: Self-checking bench for the pulse retransmit output
// Assumes: Millisecond tick shortened to five clock cycles
// Notes:   Divisor and pin levels drawn from a fixed seed
`default_nettype none
module rpo_pulse_out_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 5;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
  logic        clk, rst_n, psel, pen, pwr, pa, pb, inc, clr_a, clr_b;
  logic        pready, perr, rerr, out, ann;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] rx_n, rx_w;
  int          n_errors = 0;
  int          comparisons = 0;
  int          div, c0;
  int          ms_tab[11] = '{10, 20, 50, 100, 200, 300, 400, 500, 600, 800, 1000};

  rpo_pulse_out #(.CYC_PER_MS(CPM)) i_rpo_pulse_out (.REF_CLK_I(clk), .ARST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .PULSE_A_I(pa), .PULSE_B_I(pb),
    .TOTAL_LSD_INC_I(inc), .TOTAL_A_CLR_I(clr_a), .TOTAL_B_CLR_I(clr_b),
    .PULSE_OUT_O(out), .RETRANSMIT_ANNUNCIATOR_O(ann));
  rpo_pulse_rx i_rpo_pulse_rx (.clk_i(clk), .arst_n_i(rst_n), .line_i(out),
    .count_o(rx_n), .width_o(rx_w));

  // Clock
  always #2.5 clk = ~clk;

  // Expected scaled pulse length in clock cycles for a width selector
  function automatic int width_cyc(input int w);
    return ms_tab[w] * CPM;
  endfunction

  // Print counts and verdict, then stop
  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One register transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = perr;
    psel  <= 1'b0;
    pen   <= 1'b0;
  endtask

  // Read and compare masked bits
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata & m, e)
  endtask

  // Total digit increments, one every two cycles
  task automatic pulse_inc(input int n);
    repeat (n)
    begin
      @(posedge clk);
      inc <= 1'b1;
      @(posedge clk);
      inc <= 1'b0;
    end
  endtask

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    {clk, rst_n, psel, pen, pwr, pa, pb, inc, clr_a, clr_b} = 10'h000;
    paddr  = 12'h000;
    pwdata = 32'h0;
    c0 = $urandom(50008);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(rpo_pkg::OFS_CTRL, 32'hf, 32'h0);
    rd_chk(rpo_pkg::OFS_DIV, 32'hffff, 32'h1);
    rd_chk(rpo_pkg::OFS_STATUS, 32'hffff, 32'h0);
    rd_chk(12'h020, 32'hffffffff, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1'b1, rpo_pkg::OFS_DIV, 32'h0);
    rd_chk(rpo_pkg::OFS_DIV, 32'hffff, 32'h1);
    apb(1'b1, rpo_pkg::OFS_WIDTH, 32'hf);
    rd_chk(rpo_pkg::OFS_WIDTH, 32'hf, 32'ha);
    apb(1'b1, rpo_pkg::OFS_DIV, 32'h3);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, rpo_pkg::OFS_CTRL, 32'(1 + 2 * s));
      repeat (12)
      begin
        @(posedge clk);
        pa <= 1'($urandom);
        pb <= 1'($urandom);
        repeat (4) @(posedge clk);
        `CHK(out, (s == 1) ? pb : pa)
        `CHK(ann, 1'b1)
      end
    end
    pa <= 1'b0;
    pb <= 1'b0;
    apb(1'b1, rpo_pkg::OFS_CTRL, 32'h4);
    repeat (40)
    begin
      @(posedge clk);
      inc <= 1'($urandom);
      pa  <= 1'($urandom);
      `CHK(out, 1'b0)
    end
    inc <= 1'b0;
    apb(1'b1, rpo_pkg::OFS_CTRL, 32'hd);
    c0 = rx_n;
    pulse_inc(8);
    repeat (20) @(posedge clk);
    `CHK(rx_n, 16'(c0))
    rd_chk(rpo_pkg::OFS_STATUS, 32'h40000, 32'h0);
    apb(1'b1, rpo_pkg::OFS_CTRL, 32'h5);
    rd_chk(rpo_pkg::OFS_STATUS, 32'h40000, 32'h40000);
    div = 1 + $urandom % 4;
    apb(1'b1, rpo_pkg::OFS_DIV, 32'(div));
    for (int w = 0; w < 11; w++)
    begin
      apb(1'b1, rpo_pkg::OFS_WIDTH, 32'(w));
      c0 = rx_n;
      pulse_inc(div - 1);
      repeat (5) @(posedge clk);
      `CHK(rx_n, 16'(c0))
      pulse_inc(1);
      repeat (2 * width_cyc(w) + 10) @(posedge clk);
      `CHK(rx_n, 16'(c0 + 1))
      `CHK(rx_w + 16'h1 - 16'(width_cyc(w)) <= 16'h2, 1'b1)
    end
    apb(1'b1, rpo_pkg::OFS_WIDTH, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      c0 = rx_n;
      pulse_inc(3 * div);
      apb(1'b0, rpo_pkg::OFS_STATUS, 32'h0);
      `CHK(rdata[15:0] != 16'h0, 1'b1)
      @(posedge clk);
      clr_a <= (k == 1);
      clr_b <= (k == 2);
      @(posedge clk);
      clr_a <= 1'b0;
      clr_b <= 1'b0;
      if (k == 3)
        apb(1'b1, rpo_pkg::OFS_EVENT, 32'h1);
      if (k > 0)
        rd_chk(rpo_pkg::OFS_STATUS, 32'hffff, 32'h0);
      repeat (6 * 10 * CPM + 20) @(posedge clk);
      `CHK(rx_n, 16'(c0 + ((k == 0) ? 3 : 1)))
    end
    // Mid-run reset with pulses queued: queue and settings restart
    pulse_inc(3 * div);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(rpo_pkg::OFS_STATUS, 32'hffff, 32'h0);
    rd_chk(rpo_pkg::OFS_CTRL, 32'hf, 32'h0);
    end_sim();
  end
endmodule

bind rpo_pulse_out rpo_pulse_out_sva i_rpo_pulse_out_sva (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PULSE_A_I(PULSE_A_I), .PULSE_OUT_O(PULSE_OUT_O),
  .RETRANSMIT_ANNUNCIATOR_O(RETRANSMIT_ANNUNCIATOR_O));
`default_nettype wire
